// ==== core/supply_monitor_device.sv ====
// Monitor end: converter sequencer, status registers, alarm and configuration port
// Function
// - Enable captures address, then register data appears
// - Results readable only through port address
// - Channel drives low address bits, upper zero
// - Write enable is held low
// - Monitor reset is kept low
// - Channel output updates when busy falls
// - Result stored at channel's address, aux 02h
// - End of sequence pulses one cycle
// - End of sequence drives the port enable
// - Busy high exactly during each conversion
// - Busy rises and falls once per conversion period
// - Data may be latched on busy rise
// - Alarm high while aux outside limits
// - Port clock between 2 and 200 MHz
// - Lost port clock stops reads, not monitoring
// - Conversion is 26 divided converter cycles
// - Alarm limits are E000h upper, CAAAh lower
`timescale 1ns/1ps
`include "supply_monitor_regs.svh"

module supply_monitor_device (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rstn,
	// Measured codes from the sensor front end
	input wire supply_monitor_pkg::code_t i_aux_code,
	input wire supply_monitor_pkg::code_t i_cal_code,
	// Port clock lost, internal oscillator running
	input wire logic i_port_clock_lost,
	// Status copies for the user side
	output logic o_busy,
	output logic o_alarm,
	// Configuration port and monitor outputs
	supply_monitor_if.device bus
);

	localparam int DIV_LAST = `SM_CONV_DIV - 1;
	localparam int CONV_LAST = `SM_CONV_CYCLES - 1;
	localparam int TRACK_LAST = `SM_TRACK_CYCLES - 1;
	localparam int SEQ_LAST = `SM_SEQ_LEN - 1;

	// Whole reset: port reset or the monitor's own reset input
	logic run_ok;
	assign run_ok = i_rstn && !bus.monitor_reset;

	// Converter clock divider and phase counters
	logic [7:0] div_cnt;
	logic conv_tick;
	logic [4:0] conv_cnt;
	supply_monitor_pkg::conv_state_e conv_state;
	logic seq_idx;
	supply_monitor_pkg::code_t sample;
	logic conv_done;
	supply_monitor_pkg::channel_t cur_ch;

	// Status registers, one per channel address
	supply_monitor_pkg::code_t status_mem [`SM_STATUS_DEPTH];

	// Read pipeline
	logic rd_pend;
	supply_monitor_pkg::port_addr_t rd_addr;
	supply_monitor_pkg::code_t data_q;
	logic read_valid_q;

	// Registered outputs
	supply_monitor_pkg::channel_t channel_q;
	logic eos_q;
	logic busy_q;
	logic alarm_q;

	// Channel multiplexer address for each sequence slot
	function automatic supply_monitor_pkg::channel_t seq_channel(input logic idx);
		seq_channel = idx ? `SM_CH_AUX : `SM_CH_CAL;
	endfunction : seq_channel

	assign cur_ch = seq_channel(seq_idx);
	assign conv_tick = (div_cnt == 8'(DIV_LAST));
	assign conv_done = conv_tick && (conv_state == supply_monitor_pkg::CONV_RUN)
		&& (conv_cnt == 5'(CONV_LAST));

	// Port clock divided down to the converter clock
	always_ff @(posedge i_clk) begin
		if (!run_ok) begin
			div_cnt <= 8'h00;
		end else if (conv_tick) begin
			div_cnt <= 8'h00;
		end else begin
			div_cnt <= div_cnt + 8'h01;
		end
	end

	// Track phase then conversion phase, 26 converter cycles in all
	always_ff @(posedge i_clk) begin
		if (!run_ok) begin
			conv_state <= supply_monitor_pkg::CONV_TRACK;
			conv_cnt <= 5'h00;
		end else if (conv_tick) begin
			unique case (conv_state)
				supply_monitor_pkg::CONV_TRACK: begin
					if (conv_cnt == 5'(TRACK_LAST)) begin
						conv_state <= supply_monitor_pkg::CONV_RUN;
					end
					conv_cnt <= conv_cnt + 5'h01;
				end
				supply_monitor_pkg::CONV_RUN: begin
					if (conv_cnt == 5'(CONV_LAST)) begin
						conv_state <= supply_monitor_pkg::CONV_TRACK;
						conv_cnt <= 5'h00;
					end else begin
						conv_cnt <= conv_cnt + 5'h01;
					end
				end
			endcase
		end
	end

	// Busy follows the conversion phase, one rise and fall per period
	always_ff @(posedge i_clk) begin
		if (!run_ok) begin
			busy_q <= 1'b0;
		end else if (conv_tick) begin
			busy_q <= (conv_state == supply_monitor_pkg::CONV_TRACK)
				&& (conv_cnt == 5'(TRACK_LAST));
			if (conv_state == supply_monitor_pkg::CONV_RUN && conv_cnt != 5'(CONV_LAST)) begin
				busy_q <= 1'b1;
			end
		end
	end

	// Input sampled when tracking ends
	always_ff @(posedge i_clk) begin
		if (!run_ok) begin
			sample <= 16'h0000;
		end else if (conv_tick && conv_state == supply_monitor_pkg::CONV_TRACK
			&& conv_cnt == 5'(TRACK_LAST)) begin
			sample <= seq_idx ? i_aux_code : i_cal_code;
		end
	end

	// Sequence slot advances after each conversion
	always_ff @(posedge i_clk) begin
		if (!run_ok) begin
			seq_idx <= 1'b0;
		end else if (conv_done) begin
			seq_idx <= (seq_idx == 1'(SEQ_LAST)) ? 1'b0 : 1'b1;
		end
	end

	// Channel address shown as busy falls
	always_ff @(posedge i_clk) begin
		if (!run_ok) begin
			channel_q <= 5'h00;
		end else if (conv_done) begin
			channel_q <= cur_ch;
		end
	end

	// End of sequence after the last slot, one cycle
	always_ff @(posedge i_clk) begin
		if (!run_ok) begin
			eos_q <= 1'b0;
		end else begin
			eos_q <= conv_done && (seq_idx == 1'(SEQ_LAST));
		end
	end

	// Result written to the status register at the channel address
	genvar g;
	generate
		for (g = 0; g < `SM_STATUS_DEPTH; g++) begin : g_status
			always_ff @(posedge i_clk) begin
				if (!run_ok) begin
					status_mem[g] <= 16'h0000;
				end else if (conv_done && cur_ch == 5'(g)) begin
					status_mem[g] <= sample;
				end
			end
		end
	endgenerate

	// Alarm judged on each aux result, clears when back in range
	always_ff @(posedge i_clk) begin
		if (!run_ok) begin
			alarm_q <= 1'b0;
		end else if (conv_done && cur_ch == `SM_CH_AUX) begin
			alarm_q <= (sample > `SM_AUX_UPPER) || (sample < `SM_AUX_LOWER);
		end
	end

	// Address captured on enable; reads stop without the port clock
	always_ff @(posedge i_clk) begin
		if (!run_ok) begin
			rd_pend <= 1'b0;
			rd_addr <= 7'h00;
		end else begin
			rd_pend <= bus.cfg_port_enable && !i_port_clock_lost;
			if (bus.cfg_port_enable) begin
				rd_addr <= bus.cfg_port_address;
			end
		end
	end

	// Addressed register onto the data bus; writes are not stored
	always_ff @(posedge i_clk) begin
		if (!run_ok) begin
			data_q <= 16'h0000;
			read_valid_q <= 1'b0;
		end else begin
			read_valid_q <= rd_pend;
			if (rd_pend) begin
				if (rd_addr < 7'(`SM_STATUS_DEPTH)) begin
					data_q <= status_mem[rd_addr[4:0]];
				end else begin
					data_q <= 16'h0000;
				end
			end
		end
	end

	// Port outputs
	assign bus.port_data = data_q;
	assign bus.cfg_port_read_valid = read_valid_q;
	assign bus.channel = channel_q;
	assign bus.end_of_sequence = eos_q;
	assign bus.busy = busy_q;
	assign bus.alarm = alarm_q;
	assign o_busy = busy_q;
	assign o_alarm = alarm_q;

endmodule : supply_monitor_device

// ==== core/supply_monitor_regs.svh ====
// Constants of the supply monitor readout: widths, channels, timing and thresholds
`ifndef SUPPLY_MONITOR_REGS_SVH
`define SUPPLY_MONITOR_REGS_SVH

// Port widths
`define SM_ADDR_W 7
`define SM_DATA_W 16
`define SM_CH_W 5

// Port clock rate and converter timing
`define SM_CLK_FREQ_HZ 50000000
`define SM_CONV_DIV 10
`define SM_CONV_CYCLES 26
`define SM_TRACK_CYCLES 1
`define SM_PORT_PERIOD (`SM_CONV_DIV * `SM_CONV_CYCLES)
`define SM_CONV_RATE_HZ (`SM_CLK_FREQ_HZ / `SM_PORT_PERIOD)

// Channel multiplexer addresses in sequence order
`define SM_CH_CAL 5'h08
`define SM_CH_AUX 5'h02
`define SM_SEQ_LEN 2

// Status register file size
`define SM_STATUS_DEPTH 32

// Auxiliary supply alarm limits, limit / 3 V * 65536
`define SM_AUX_UPPER 16'hE000
`define SM_AUX_LOWER 16'hCAAA

// Read pipeline: edges from enable to read valid
`define SM_READ_LATENCY 2

`endif

// ==== core/supply_monitor_pkg.sv ====
// Types shared by both ends of the supply monitor readout
`include "supply_monitor_regs.svh"

package supply_monitor_pkg;

	// Converter phase
	typedef enum logic {
		CONV_TRACK,
		CONV_RUN
	} conv_state_e;

	typedef logic [`SM_DATA_W-1:0] code_t;
	typedef logic [`SM_ADDR_W-1:0] port_addr_t;
	typedef logic [`SM_CH_W-1:0] channel_t;

endpackage : supply_monitor_pkg

// ==== core/supply_monitor_if.sv ====
// Interface joining the monitor and the user logic that reads it
`timescale 1ns/1ps

interface supply_monitor_if;
	supply_monitor_pkg::port_addr_t cfg_port_address;
	logic cfg_port_enable;
	logic cfg_port_write_enable;
	logic monitor_reset;
	supply_monitor_pkg::code_t port_data;
	logic cfg_port_read_valid;
	supply_monitor_pkg::channel_t channel;
	logic end_of_sequence;
	logic busy;
	logic alarm;

	// Monitor end
	modport device (
		input cfg_port_address, cfg_port_enable, cfg_port_write_enable, monitor_reset,
		output port_data, cfg_port_read_valid, channel, end_of_sequence, busy, alarm
	);

	// User logic end
	modport host (
		output cfg_port_address, cfg_port_enable, cfg_port_write_enable, monitor_reset,
		input port_data, cfg_port_read_valid, channel, end_of_sequence, busy, alarm
	);
endinterface : supply_monitor_if

// ==== core/supply_monitor_host.sv ====
// User logic end: feeds channel back as address and collects the aux result
`timescale 1ns/1ps
`include "supply_monitor_regs.svh"

module supply_monitor_host (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rstn,
	// Configuration port and monitor outputs
	supply_monitor_if.host bus,
	// Results for the user
	output supply_monitor_pkg::code_t o_aux_result,
	output logic o_aux_valid,
	output supply_monitor_pkg::code_t o_busy_capture,
	output logic o_alarm
);

	logic busy_d;
	supply_monitor_pkg::code_t result_q;
	logic valid_q;
	supply_monitor_pkg::code_t capture_q;

	// Fixed hookup: channel as address, end of sequence as enable
	assign bus.cfg_port_address = {2'h0, bus.channel};
	assign bus.cfg_port_enable = bus.end_of_sequence;
	assign bus.cfg_port_write_enable = 1'b0;
	assign bus.monitor_reset = 1'b0;

	// Result kept when read valid returns
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			result_q <= 16'h0000;
			valid_q <= 1'b0;
		end else begin
			valid_q <= bus.cfg_port_read_valid;
			if (bus.cfg_port_read_valid) begin
				result_q <= bus.port_data;
			end
		end
	end

	// Data bus latched on the rising edge of busy
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			busy_d <= 1'b0;
			capture_q <= 16'h0000;
		end else begin
			busy_d <= bus.busy;
			if (bus.busy && !busy_d) begin
				capture_q <= bus.port_data;
			end
		end
	end

	assign o_aux_result = result_q;
	assign o_aux_valid = valid_q;
	assign o_busy_capture = capture_q;
	assign o_alarm = bus.alarm;

endmodule : supply_monitor_host

// ==== test/supply_monitor_assertions.sv ====
// Concurrent checks on the readout interface
`timescale 1ns/1ps
module supply_monitor_assertions (
	// Clock, reset, loss flag
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic i_port_clock_lost,
	// Interface signals
	input wire supply_monitor_pkg::port_addr_t cfg_port_address,
	input wire logic cfg_port_enable,
	input wire logic cfg_port_write_enable,
	input wire logic monitor_reset,
	input wire supply_monitor_pkg::code_t port_data,
	input wire logic cfg_port_read_valid,
	input wire supply_monitor_pkg::channel_t channel,
	input wire logic end_of_sequence,
	input wire logic busy,
	input wire logic alarm
);
	logic [8:0] hi_cnt;
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rstn);
	// Length of the current busy span
	always_ff @(posedge i_clk) begin
		if (!i_rstn || !busy)
			hi_cnt <= 9'h000;
		else
			hi_cnt <= hi_cnt + 9'h001;
	end
	// Ten cycles of tracking
	sequence track_phase;
		!busy [*8] ##1 !busy ##1 !busy;
	endsequence
	a_read_latency: assert property (cfg_port_enable && !i_port_clock_lost |-> ##2 cfg_port_read_valid)
		else $error("read valid late");
	a_valid_cause: assert property (cfg_port_read_valid |-> $past(cfg_port_enable, 2))
		else $error("read valid without enable");
	a_data_hold: assert property (!cfg_port_read_valid |-> $stable(port_data))
		else $error("data changed without read");
	a_eos_pulse: assert property (end_of_sequence |=> !end_of_sequence)
		else $error("end of sequence too long");
	a_eos_after_aux: assert property (end_of_sequence |-> $fell(busy) && channel == 5'h02)
		else $error("end of sequence not after aux");
	a_channel_on_fall: assert property (!$stable(channel) |-> $fell(busy))
		else $error("channel moved off busy fall");
	a_track_span: assert property ($fell(busy) |-> track_phase ##1 busy)
		else $error("track phase length");
	a_busy_span: assert property ($fell(busy) |-> hi_cnt == 9'h0FA)
		else $error("busy high length");
	a_alarm_update: assert property (!$stable(alarm) |-> end_of_sequence)
		else $error("alarm moved off aux result");
	a_host_wiring: assert property (cfg_port_address == {2'h0, channel} && cfg_port_enable == end_of_sequence
		&& !cfg_port_write_enable && !monitor_reset)
		else $error("host wiring");
	a_lost_no_read: assert property (i_port_clock_lost && cfg_port_enable |-> ##2 !cfg_port_read_valid)
		else $error("read while clock lost");
endmodule : supply_monitor_assertions

// ==== test/tb_supply_monitor_readout.sv ====
// Self-checking bench joining both ends of the readout
`timescale 1ns/1ps
module tb_supply_monitor_readout;
	logic i_clk = 1'b0;
	logic i_rstn = 1'b0;
	logic i_port_clock_lost = 1'b0;
	supply_monitor_pkg::code_t i_aux_code = 16'hD555;
	supply_monitor_pkg::code_t i_cal_code = 16'h0000;
	logic dev_busy, dev_alarm, aux_valid, host_alarm;
	supply_monitor_pkg::code_t aux_result, busy_capture, held;
	supply_monitor_pkg::code_t corner [7] = '{16'hE000, 16'hE001, 16'hCAAA, 16'hCAA9, 16'h0000, 16'hFFFF, 16'hD555};
	int n_fail = 0;
	int checks_done = 0;
	integer seed = 73373;
	bit got;
	supply_monitor_if bus ();
	supply_monitor_device u_supply_monitor_device (.i_clk(i_clk), .i_rstn(i_rstn), .i_aux_code(i_aux_code),
		.i_cal_code(i_cal_code), .i_port_clock_lost(i_port_clock_lost), .o_busy(dev_busy), .o_alarm(dev_alarm), .bus(bus));
	supply_monitor_host u_supply_monitor_host (.i_clk(i_clk), .i_rstn(i_rstn), .bus(bus), .o_aux_result(aux_result),
		.o_aux_valid(aux_valid), .o_busy_capture(busy_capture), .o_alarm(host_alarm));
	supply_monitor_assertions u_supply_monitor_assertions (.i_clk(i_clk), .i_rstn(i_rstn),
		.i_port_clock_lost(i_port_clock_lost), .cfg_port_address(bus.cfg_port_address),
		.cfg_port_enable(bus.cfg_port_enable), .cfg_port_write_enable(bus.cfg_port_write_enable),
		.monitor_reset(bus.monitor_reset), .port_data(bus.port_data), .cfg_port_read_valid(bus.cfg_port_read_valid),
		.channel(bus.channel), .end_of_sequence(bus.end_of_sequence), .busy(bus.busy), .alarm(bus.alarm));
	// 50 MHz clock, inside the allowed port clock range
	always #10 i_clk = ~i_clk;
	// Compare a word
	task automatic check16(input string what, input supply_monitor_pkg::code_t exp, input supply_monitor_pkg::code_t v);
		checks_done++;
		if (v !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", what, exp, v);
		end
	endtask : check16
	// Compare a flag
	task automatic check1(input string what, input logic exp, input logic v);
		check16(what, {15'h0000, exp}, {15'h0000, v});
	endtask : check1
	// Alarm expected for an aux code
	function automatic logic exp_alarm(input supply_monitor_pkg::code_t c);
		return (c > 16'hE000) || (c < 16'hCAAA);
	endfunction : exp_alarm
	// Wait for end of sequence (0) or result valid (1)
	task automatic wait_for(input int which, input int lim);
		got = 1'b0;
		for (int i = 0; i < lim && !got; i++) begin
			@(negedge i_clk);
			got = ((which == 0) ? bus.end_of_sequence : aux_valid) === 1'b1;
		end
	endtask : wait_for
	// Apply a code, let a sequence finish, check the readout
	task automatic run_seq(input supply_monitor_pkg::code_t c);
		@(negedge i_clk);
		i_aux_code = c;
		i_cal_code = 16'($random(seed));
		held = aux_result;
		wait_for(0, 600);
		check1("end of sequence", 1'b1, got);
		check1("busy low at end of sequence", 1'b0, dev_busy);
		check16("channel", 16'h0002, {11'h000, bus.channel});
		wait_for(1, 8);
		check1("aux valid", !i_port_clock_lost, got);
		check16("aux result", i_port_clock_lost ? held : c, aux_result);
		check1("alarm", exp_alarm(c), host_alarm);
		check1("device alarm", exp_alarm(c), dev_alarm);
		if (!i_port_clock_lost) begin
			repeat (12) @(negedge i_clk);
			check1("busy high in next conversion", 1'b1, dev_busy);
			check16("busy capture", c, busy_capture);
		end
	endtask : run_seq
	// Print counts and verdict
	task automatic give_verdict();
		$display("Checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : give_verdict
	// Main sequence
	initial begin
		repeat (16) @(negedge i_clk);
		i_rstn = 1'b1;
		foreach (corner[i]) run_seq(corner[i]);
		for (int i = 0; i < 6; i++) run_seq(16'($random(seed)));
		i_port_clock_lost = 1'b1;
		run_seq(16'hF000);
		i_port_clock_lost = 1'b0;
		run_seq(16'hD000);
		i_rstn = 1'b0;
		repeat (2) @(negedge i_clk);
		check1("busy in reset", 1'b0, dev_busy);
		check16("data in reset", 16'h0000, bus.port_data);
		i_rstn = 1'b1;
		run_seq(16'hC000);
		give_verdict();
	end
	// Watchdog
	initial begin
		#400000;
		n_fail++;
		give_verdict();
	end
endmodule : tb_supply_monitor_readout
